//--- design/ldr_consts.vh
/*
 * constants for the lut distributed ram block: mode codes, widths,
 * register offsets and field positions of the axi4-lite control port.
 * assumes inclusion by bare name from the design file only.
 */
// Summary of operation
// - writes are clocked; reads are combinational from the address.
// - single-port mode offers one 16x1, two 16x1, or one 32x1 array.
// - dual-port mode offers only one 16x1 array.
// - single 16x1: 16 bits, one 4-bit address, one data in, one out.
// - paired 16x1: two arrays, each with own data in, out and address.
// - paired 16x1: one write strobe and write clock shared by both.
// - 32x1: 32 bits, one 5-bit address, one data in, one out.
// - address and bit held at active edge with strobe high get stored.
// - active edge captures address, bit, strobe; a pulse then writes.
// - active write edge selectable rising or falling, rising by default.
// - write strobe is active high and cannot be inverted.
// - port one output always shows the addressed location's contents.
// - overwriting the addressed location shows the new bit shortly after.
// - dual-port: port one index reads and writes, second index reads only.
// - dual-port: two copies written at port one index, read separately.
// - contents load an initial value at configuration, zero by default.
// - contents load only at configuration; global set/reset leaves them.
// - built from the tile's two 16-entry lookup tables.
`ifndef LDR_CONSTS_VH
`define LDR_CONSTS_VH

// ----------------------------------------------------------------
// arrangement codes
// ----------------------------------------------------------------
`define LDR_MODE_W        2
`define LDR_MODE_SP16     2'h0
`define LDR_MODE_SP16X2   2'h1
`define LDR_MODE_SP32     2'h2
`define LDR_MODE_DP16     2'h3

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define LDR_DEPTH         16
`define LDR_AW            4

// ----------------------------------------------------------------
// axi4-lite register map (byte addresses)
// ----------------------------------------------------------------
`define LDR_OFF_CTRL      4'h0
`define LDR_OFF_STAT      4'h4
`define LDR_OFF_INIT      4'h8
`define LDR_OFF_CONT      4'hc
`define LDR_CTRL_MODE_LSB 0
`define LDR_CTRL_EDGE_BIT 2
`define LDR_CTRL_W        3
`define LDR_CTRL_RST      3'h0
`define LDR_RESP_OKAY     2'h0
`define LDR_RESP_SLVERR   2'h2
`define LDR_STAT_P1_BIT   0
`define LDR_STAT_P2_BIT   1
`define LDR_INIT_ZERO     32'h00000000

`endif

//--- design/ldr_ram.v
/*
 * lut distributed ram: two 16-entry one-bit lookup tables used as
 * memory, arranged as 16x1, two 16x1, 32x1 or dual-port 16x1, with a
 * small axi4-lite port for arrangement, write edge and status.
 * assumes user write signals come from logic on aclk; the active write
 * edge is emulated by sampling the edge of write_clock_in on aclk.
 */
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ldr_consts.vh"

module ldr_ram #(
	parameter [31:0] INITIAL_CONTENTS = `LDR_INIT_ZERO
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// configuration load and global set/reset
	input  wire        config_load,
	input  wire        global_set_reset,
	// user write and read ports
	input  wire        write_clock_in,
	input  wire        write_strobe,
	input  wire [4:0]  port_one_index,
	input  wire        write_bit_value,
	input  wire [3:0]  second_port_index,
	input  wire        second_write_bit_value,
	output wire        port_one_output,
	output wire        second_port_output,
	// axi4-lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	reg  [`LDR_CTRL_W-1:0] ctrl_q;
	wire [1:0] mode = ctrl_q[`LDR_CTRL_MODE_LSB+1:`LDR_CTRL_MODE_LSB];
	wire       fall_edge = ctrl_q[`LDR_CTRL_EDGE_BIT];

	// ----------------------------------------------------------------
	// write clock edge detection
	// ----------------------------------------------------------------
	// the write clock is a pin: two flops before anything looks at it
	reg wclk_s1_q;
	reg wclk_s2_q;
	reg wclk_s3_q;
	always @(posedge aclk) begin
		wclk_s1_q <= write_clock_in;
		wclk_s2_q <= wclk_s1_q;
		wclk_s3_q <= wclk_s2_q;
	end
	// pin edges closer than about one aclk period are lost: the price
	// of keeping the whole block on one clock
	wire rise = wclk_s2_q & ~wclk_s3_q;
	wire fall = ~wclk_s2_q & wclk_s3_q;
	wire active_edge = fall_edge ? fall : rise;

	// ----------------------------------------------------------------
	// capture stage, then internal write pulse
	// ----------------------------------------------------------------
	// strobe used as-is, no inversion option exists
	reg       cap_we_q;
	reg [4:0] cap_a_q;
	reg [3:0] cap_b_q;
	reg       cap_d_q;
	reg       cap_e_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			cap_we_q <= 1'b0;
			cap_a_q  <= 5'h00;
			cap_b_q  <= 4'h0;
			cap_d_q  <= 1'b0;
			cap_e_q  <= 1'b0;
		end else begin
			cap_we_q <= active_edge & write_strobe;
			if (active_edge) begin
				cap_a_q <= port_one_index;
				cap_b_q <= second_port_index;
				cap_d_q <= write_bit_value;
				cap_e_q <= second_write_bit_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// the two lookup tables
	// ----------------------------------------------------------------
	// lower and upper 16-entry tables; no reset term, so neither
	// aresetn nor global set/reset disturbs them
	wire [`LDR_DEPTH-1:0] lut_f_cells;
	wire [`LDR_DEPTH-1:0] lut_g_cells;
	wire                  rd_f;
	wire                  rd_g_a;
	wire                  rd_g_b;
	reg                   we_f;
	reg                   we_g;
	reg  [`LDR_AW-1:0]    wa_f;
	reg  [`LDR_AW-1:0]    wa_g;
	reg                   wd_f;
	reg                   wd_g;

	always @* begin
		we_f = 1'b0;
		we_g = 1'b0;
		wa_f = cap_a_q[3:0];
		wa_g = cap_a_q[3:0];
		wd_f = cap_d_q;
		wd_g = cap_d_q;
		case (mode)
		`LDR_MODE_SP16: begin
			we_f = cap_we_q;
		end
		`LDR_MODE_SP16X2: begin
			we_f = cap_we_q;
			we_g = cap_we_q;
			wa_g = cap_b_q;
			wd_g = cap_e_q;
		end
		`LDR_MODE_SP32: begin
			we_f = cap_we_q & ~cap_a_q[4];
			we_g = cap_we_q & cap_a_q[4];
		end
		`LDR_MODE_DP16: begin
			we_f = cap_we_q;
			we_g = cap_we_q;
		end
		default: begin
			we_f = 1'b0;
		end
		endcase
	end

	// contents load only on the configuration strobe
	ldr_lut16 #(
		.DEPTH      (`LDR_DEPTH),
		.AW         (`LDR_AW)
	) lut_f_u (
		.aclk       (aclk),
		.load       (config_load),
		.load_value (INITIAL_CONTENTS[`LDR_DEPTH-1:0]),
		.we         (we_f),
		.wa         (wa_f),
		.wd         (wd_f),
		.ra_a       (port_one_index[`LDR_AW-1:0]),
		.ra_b       (second_port_index),
		.rd_a       (rd_f),
		.rd_b       (),
		.cells_q    (lut_f_cells)
	);

	ldr_lut16 #(
		.DEPTH      (`LDR_DEPTH),
		.AW         (`LDR_AW)
	) lut_g_u (
		.aclk       (aclk),
		.load       (config_load),
		.load_value (INITIAL_CONTENTS[2*`LDR_DEPTH-1:`LDR_DEPTH]),
		.we         (we_g),
		.wa         (wa_g),
		.wd         (wd_g),
		.ra_a       (port_one_index[`LDR_AW-1:0]),
		.ra_b       (second_port_index),
		.rd_a       (rd_g_a),
		.rd_b       (rd_g_b),
		.cells_q    (lut_g_cells)
	);

	// ----------------------------------------------------------------
	// asynchronous reads
	// ----------------------------------------------------------------
	// reads follow the address with no clock; a write to the shown
	// location appears one cycle after its pulse

	assign port_one_output = (mode == `LDR_MODE_SP32 &&
		port_one_index[4]) ? rd_g_a : rd_f;
	// second output is the upper copy in dual-port mode
	// and the second array in paired mode; 16x1 and 32x1 leave it 0
	// because dual-port has no wider arrangement
	assign second_port_output = (mode == `LDR_MODE_DP16 ||
		mode == `LDR_MODE_SP16X2) ? rd_g_b : 1'b0;

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	// both address and data held until both present; simple and one
	// write outstanding at a time
	reg wr_go;
	always @* begin
		wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	end
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q       <= `LDR_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LDR_RESP_OKAY;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr == `LDR_OFF_CTRL) begin
					s_axi_bresp <= `LDR_RESP_OKAY;
					if (s_axi_wstrb[0])
						ctrl_q <= s_axi_wdata[`LDR_CTRL_W-1:0];
				end else if (s_axi_awaddr == `LDR_OFF_STAT ||
					s_axi_awaddr == `LDR_OFF_INIT ||
					s_axi_awaddr == `LDR_OFF_CONT) begin
					s_axi_bresp <= `LDR_RESP_OKAY;
				end else begin
					s_axi_bresp <= `LDR_RESP_SLVERR;
				end
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `LDR_RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `LDR_RESP_OKAY;
				case (s_axi_araddr)
				`LDR_OFF_CTRL: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rdata[`LDR_CTRL_W-1:0] <= ctrl_q;
				end
				`LDR_OFF_STAT: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rdata[`LDR_STAT_P1_BIT] <= port_one_output;
					s_axi_rdata[`LDR_STAT_P2_BIT] <= second_port_output;
				end
				`LDR_OFF_INIT: begin
					s_axi_rdata <= INITIAL_CONTENTS;
				end
				`LDR_OFF_CONT: begin
					s_axi_rdata <= {lut_g_cells, lut_f_cells};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `LDR_RESP_SLVERR;
				end
				endcase
			end
		end
	end

endmodule

// ----------------------------------------------------------------
// one 16-entry one-bit lookup table used as memory
// ----------------------------------------------------------------
// two independent read muxes; the upper table's second mux serves the second port,
// read-only in dual-port mode, where it reads a second copy of the cells
module ldr_lut16 #(
	parameter DEPTH = `LDR_DEPTH,
	parameter AW    = `LDR_AW
) (
	// clock
	input  wire             aclk,
	// configuration load
	input  wire             load,
	input  wire [DEPTH-1:0] load_value,
	// synchronous write port
	input  wire             we,
	input  wire [AW-1:0]    wa,
	input  wire             wd,
	// asynchronous read ports
	input  wire [AW-1:0]    ra_a,
	input  wire [AW-1:0]    ra_b,
	output wire             rd_a,
	output wire             rd_b,
	// whole contents for readback
	output reg  [DEPTH-1:0] cells_q
);

	// no reset term: only the load strobe or a write changes a cell
	always @(posedge aclk) begin
		if (load) begin
			cells_q <= load_value;
		end else if (we) begin
			cells_q[wa] <= wd;
		end
	end

	assign rd_a = cells_q[ra_a];
	assign rd_b = cells_q[ra_b];

endmodule

//--- tb/ldr_ram_properties.sv
/* port checker for ldr_ram; assumes one aclk domain, bound below */
`timescale 1ns/10ps
module ldr_ram_properties #(parameter [31:0] INITIAL_CONTENTS = 32'h0) (
	input wire        aclk, aresetn, config_load, global_set_reset,
	input wire        write_clock_in, port_one_output, second_port_output,
	input wire [4:0]  port_one_index,
	input wire [3:0]  second_port_index, s_axi_awaddr,
	input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
	input wire        s_axi_wready, s_axi_bvalid, s_axi_bready,
	input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [1:0]  s_axi_bresp,
	input wire [31:0] s_axi_rdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// quiet counters: a pin edge lands about four cycles later
	reg  [3:0] wq_q, q_q;
	wire [9:0] ins_w = {write_clock_in, port_one_index, second_port_index};
	wire       wr_w = s_axi_awvalid && s_axi_wvalid && s_axi_awready
		&& s_axi_wready;
	always @(posedge aclk) begin
		if (!aresetn || !$stable(write_clock_in)) wq_q <= 4'h0;
		else if (wq_q != 4'hf) wq_q <= wq_q + 4'h1;
		if (!aresetn || !$stable(ins_w) || config_load || s_axi_awvalid)
			q_q <= 4'h0;
		else if (q_q != 4'hf) q_q <= q_q + 4'h1;
	end
	AST_READ_STEADY: assert property (q_q >= 4'h6 && $stable(ins_w) |->
		$stable({port_one_output, second_port_output}))
		else $error("read output moved without cause");
	AST_CFG_LOAD: assert property ($past(config_load) && wq_q >= 4'h6 |->
		(port_one_output == INITIAL_CONTENTS[port_one_index[3:0]]
		|| port_one_output == INITIAL_CONTENTS[port_one_index])
		&& (!second_port_output
		|| INITIAL_CONTENTS[{1'b1, second_port_index}]))
		else $error("loaded contents not shown");
	AST_B_ANSWER: assert property (wr_w |=> s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read response late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	AST_AW_PAIR: assert property (s_axi_awready |-> s_axi_awvalid
		&& s_axi_wvalid && !s_axi_bvalid) else $error("lone aw taken");
	AST_MAPPED_OK: assert property (wr_w && s_axi_awaddr[1:0] == 2'h0 |=>
		s_axi_bresp == 2'h0) else $error("mapped write refused");
	AST_RST_IDLE: assert property (disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid) else $error("busy in reset");
	cover property (wr_w);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (q_q >= 4'h6 && global_set_reset);
endmodule
bind ldr_ram ldr_ram_properties #(.INITIAL_CONTENTS(INITIAL_CONTENTS)) chk_u (.*);

//--- tb/ldr_user_model.sv
/* user logic on the write port; assumes the bench's aclk */
`timescale 1ns/10ps
module ldr_user_model (
	input  wire       aclk,
	output reg        write_clock_in, write_strobe,
	output reg        write_bit_value, second_write_bit_value,
	output reg  [4:0] port_one_index,
	output reg  [3:0] second_port_index
);
	initial {write_clock_in, write_strobe, write_bit_value,
		second_write_bit_value, port_one_index, second_port_index} = 12'h0;
	// one active edge per call; inputs held six cycles past it
	task wr(input f, input [4:0] a, input [3:0] b, input s, d, d2);
		begin
			@(posedge aclk);
			write_clock_in <= f;
			{port_one_index, second_port_index} <= {a, b};
			{write_strobe, write_bit_value, second_write_bit_value} <= {s, d, d2};
			repeat (4) @(posedge aclk);
			write_clock_in <= !f;
			repeat (6) @(posedge aclk);
		end
	endtask
	task rd(input [4:0] a, input [3:0] b);
		begin
			@(posedge aclk);
			{port_one_index, second_port_index} <= {a, b};
			@(posedge aclk);
		end
	endtask
endmodule

//--- tb/ldr_ram_tb_top.sv
/* self-checking bench for ldr_ram; user side from ldr_user_model */
`timescale 1ns/10ps
module ldr_ram_tb_top;
	localparam [31:0] INIT = 32'h96c35a0f;
	reg        aclk, aresetn, config_load, global_set_reset;
	reg        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	reg        s_axi_rready;
	reg  [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	reg [31:0] s_axi_wdata, rd, cv;
	wire       write_clock_in, write_strobe, write_bit_value;
	wire       second_write_bit_value, port_one_output, second_port_output;
	wire       s_axi_awready, s_axi_wready, s_axi_arready;
	wire       s_axi_bvalid, s_axi_rvalid;
	wire [4:0] port_one_index;
	wire [3:0] second_port_index;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	reg        mem [0:31];
	reg  [4:0] a;
	reg  [3:0] b;
	reg  [1:0] rr;
	reg        s, d, d2;
	integer    n_fail, check_count, seed, i, k;
	ldr_ram #(.INITIAL_CONTENTS(INIT)) dut_u (.*);
	ldr_user_model user_u (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task chk(input [31:0] seen, want);
		begin
			check_count = check_count + 1;
			if (seen !== want) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: saw %h want %h", $time, seen, want);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	task axw(input [3:0] ad, input [31:0] dt);
		begin
			{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {ad, dt, 4'hf};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
			do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
			{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
			do @(posedge aclk); while (!s_axi_bvalid);
			rr = s_axi_bresp;
			s_axi_bready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task axr(input [3:0] ad);
		begin
			{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
			do @(posedge aclk); while (!s_axi_arready);
			s_axi_arvalid <= 1'b0;
			do @(posedge aclk); while (!s_axi_rvalid);
			{rd, rr} = {s_axi_rdata, s_axi_rresp};
			s_axi_rready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	function e1(input [1:0] m, input [4:0] x);
		e1 = mem[(m == 2'h2) ? x : {1'b0, x[3:0]}];
	endfunction
	function e2(input [1:0] m, input [3:0] y);
		e2 = m[0] ? mem[{1'b1, y}] : 1'b0;
	endfunction
	initial begin
		#100000;
		n_fail = n_fail + 1;
		conclude;
	end
	initial begin
		{seed, n_fail, check_count} = {32'd3625, 64'd0};
		{aresetn, config_load, global_set_reset} = 3'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
		{s_axi_wstrb, s_axi_wdata} = 36'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(4'h0); chk(rd, 32'h0);
		axr(4'h8); chk(rd, INIT);
		axr(4'h6); chk(rr, 2'h2);
		axw(4'h6, 32'h00000007);
		chk(rr, 32'h00000002);
		axr(4'h0);
		chk(rd, 32'h00000000);
		config_load <= 1'b1;
		@(posedge aclk) config_load <= 1'b0;
		for (i = 0; i < 32; i = i + 1) mem[i] = INIT[i];
		global_set_reset <= 1'b1;
		repeat (10) @(posedge aclk);
		global_set_reset <= 1'b0;
		axr(4'hc); chk(rd, INIT);
		for (i = 0; i < 4; i = i + 1) begin
			axw(4'h0, {29'h0, i[0], i[1:0]});
			chk(rr, 32'h00000000);
			for (k = 0; k < 24; k = k + 1) begin
				{a, b, s, d, d2} = $random(seed);
				if (k < 2) {a, s} = {5'h1f - k[4:0], 1'b1};
				user_u.wr(i[0], a, b, s, d, d2);
				if (s) begin
					mem[(i == 2) ? a : {1'b0, a[3:0]}] = d;
					if (i == 1) mem[{1'b1, b}] = d2;
					if (i == 3) mem[{1'b1, a[3:0]}] = d;
				end
				chk(port_one_output, e1(i[1:0], a));
				chk(second_port_output, e2(i[1:0], b));
				{a, b} = $random(seed);
				user_u.rd(a, b);
				chk(port_one_output, e1(i[1:0], a));
				chk(second_port_output, e2(i[1:0], b));
			end
			for (k = 0; k < 32; k = k + 1) cv[k] = mem[k];
			axr(4'hc); chk(rd, cv);
			axr(4'h4);
			chk(rd, {30'h0, e2(i[1:0], b), e1(i[1:0], a)});
		end
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(4'h0);
		chk(rd, 32'h00000000);
		axr(4'hc);
		chk(rd, cv);
		conclude;
	end
endmodule
